// ---- src/wrc_watchdog_reset_control.sv ----
// Watchdog timer with keyed control, reset-cause flag and reset sequencing.
// Assumes all inputs synchronous to hclk and a single AHB-Lite master.
//
// Overview of operation
// [RULE_01] Watchdog counts only the low-speed tick derived for the 32kHz clock.
// [RULE_02] Period code 000..111 selects 2^8,10,12,14,15,16,17,18 low-speed ticks.
// [RULE_03] Key 01010 enables, 10101 disables, anything else resets the device.
// [RULE_04] Invalid key waits the software-reset delay, then resets and sets key flag.
// [RULE_05] Control register powers up 0x53: enabled, period code 011.
// [RULE_06] Key reset flag set only by key reset, cleared only by writing zero.
// [RULE_07] Overflow when running resets device and sets timeout flag.
// [RULE_08] Overflow in sleep or idle sets timeout, resets only PC and stack.
// [RULE_09] Counter cleared by key reset, clear instruction, halt, or pin low.
// [RULE_10] One clear instruction alone clears the watchdog.
// [RULE_11] Every reset returns the program counter to zero.
// [RULE_12] Power-on sets port data and direction registers to all ones.
// [RULE_13] Pin low holds the device; after release an extra delay elapses.
// [RULE_14] Pin reset acts only when option and pin control both select it.
// [RULE_15] Pin reset is a warm reset; port registers keep their values.
// [RULE_16] Halt clears counter; it runs on if enabled, stays stopped if not.
// [RULE_17] Halt sets power-down, clears timeout; clear instruction clears power-down.
// [RULE_18] 18-bit up-counter; overflow when selected low bits are all ones.
// [RULE_19] Software-reset and pin start-up delays are cycle-count parameters.
`default_nettype none

module wrc_watchdog_reset_control
  import wrc_pkg::*;
#(
  parameter int unsigned SW_RESET_DLY_CYC  = SW_RESET_DELAY_CYC,       // [RULE_19]
  parameter int unsigned PIN_EXTRA_DLY_CYC = PIN_RESET_EXTRA_DELAY_CYC // [RULE_19]
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        clear_watchdog_instruction_i,
  input  wire logic        halt_i,
  input  wire logic        low_power_i,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        cfg_reset_pin_en,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             dev_reset_o,
  output logic             pc_sp_reset_o,
  output logic             timeout_flag_o,
  output logic             power_down_flag_o,
  output logic             pin_is_io_o,
  output logic [7:0]       port_data_o,
  output logic [7:0]       port_dir_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (SW_RESET_DLY_CYC < 1 || SW_RESET_DLY_CYC > 65535 ||
      PIN_EXTRA_DLY_CYC < 3 || PIN_EXTRA_DLY_CYC > 65535) begin : g_chk
    $error("wrc: delay counts out of range");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [8:0]       div_r;
  logic             ls_tick_r;
  logic [7:0]       watchdog_control_r;
  logic             wrf_r;
  logic             pin_sel_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mask;
  logic [15:0]      dly_r;
  wrc_state_t       state_r;
  wrc_state_t       state_nxt;
  wrc_ahb_req_t     req_r;
  logic [4:0]       key;
  logic             key_en;
  logic             key_bad;
  logic             pin_act;
  logic             ovf;
  logic             fire_sw;
  logic             fire_up;
  logic             in_rst_nxt;
  logic             soft_rst;
  logic             cnt_clr;
  logic             wr_en;
  logic             rd_take;

  // ----------------------------------------
  // Low-speed tick
  // ----------------------------------------
  // Fractional part of the divide is dropped; the low-speed clock is loose anyway
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r     <= 9'h000;
      ls_tick_r <= 1'b0;
    end else if (div_r == 9'(LS_DIV_CYC - 1)) begin // [RULE_01]
      div_r     <= 9'h000;
      ls_tick_r <= 1'b1;
    end else begin
      div_r     <= div_r + 9'h001;
      ls_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign key     = watchdog_control_r[7:KEY_LSB];
  assign key_en  = (key == KEY_ENABLE);                    // [RULE_03]
  assign key_bad = !key_en && (key != KEY_DISABLE);        // [RULE_03]
  assign pin_act = cfg_reset_pin_en && pin_sel_r && !ext_reset_pin_n; // [RULE_14]
  assign mask    = wrc_period_mask(watchdog_control_r[2:0]);           // [RULE_02]
  assign ovf     = ls_tick_r && key_en && (state_r == ST_RUN) &&
                   ((cnt_r & mask) == mask);               // [RULE_18]
  assign fire_sw = (state_r == ST_SW_WAIT) && (dly_r == 16'(SW_RESET_DLY_CYC - 1));
  assign fire_up = (state_r == ST_STARTUP) && (dly_r == 16'(PIN_EXTRA_DLY_CYC - 1));
  assign in_rst_nxt = (state_nxt == ST_PIN_LOW) || (state_nxt == ST_STARTUP);
  assign soft_rst   = in_rst_nxt && !dev_reset_o;
  assign wr_en      = req_r.valid && req_r.write;
  assign rd_take    = hsel && htrans[1] && hready && !hwrite;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (pin_act)
          state_nxt = ST_PIN_LOW;
        else if (key_bad)
          state_nxt = ST_SW_WAIT;                          // [RULE_04]
        else if (ovf && !low_power_i)
          state_nxt = ST_STARTUP;                          // [RULE_07]
      end
      ST_SW_WAIT: begin
        if (pin_act)
          state_nxt = ST_PIN_LOW;
        else if (fire_sw)
          state_nxt = ST_STARTUP;                          // [RULE_04]
      end
      ST_PIN_LOW: begin
        if (!pin_act)
          state_nxt = ST_STARTUP;                          // [RULE_13]
      end
      ST_STARTUP: begin
        if (pin_act)
          state_nxt = ST_PIN_LOW;
        else if (fire_up)
          state_nxt = ST_RUN;                              // [RULE_13]
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RUN;
      dly_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      dly_r   <= (state_nxt != state_r) ? 16'h0000 : dly_r + 16'h0001;
    end
  end

  // Core reset forces PC to zero; held while pin low and during start-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_reset_o   <= 1'b1;
      pc_sp_reset_o <= 1'b0;
    end else begin
      dev_reset_o   <= in_rst_nxt;                         // [RULE_11] [RULE_13]
      pc_sp_reset_o <= ovf && low_power_i;                 // [RULE_08]
    end
  end

  // ----------------------------------------
  // Watchdog counter
  // ----------------------------------------
  assign cnt_clr = key_bad || clear_watchdog_instruction_i || halt_i || pin_act || ovf || dev_reset_o;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_r <= '0;
    else if (cnt_clr)
      cnt_r <= '0;                                         // [RULE_09] [RULE_10] [RULE_16]
    else if (ls_tick_r && key_en && state_r == ST_RUN)
      cnt_r <= cnt_r + 18'h00001;                          // [RULE_01] [RULE_16]
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Set beats clear so an overflow in the halt cycle is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_flag_o    <= 1'b0;
      power_down_flag_o <= 1'b0;
    end else begin
      if (ovf)
        timeout_flag_o <= 1'b1;                            // [RULE_07] [RULE_08]
      else if (halt_i)
        timeout_flag_o <= 1'b0;                            // [RULE_17]
      if (halt_i)
        power_down_flag_o <= 1'b1;                         // [RULE_17]
      else if (clear_watchdog_instruction_i)
        power_down_flag_o <= 1'b0;                         // [RULE_17]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wrf_r <= 1'b0;
    else if (fire_sw)
      wrf_r <= 1'b1;                                       // [RULE_06]
    else if (wr_en && req_r.addr == ADDR_RST_CAUSE && !hwdata[WRF_BIT])
      wrf_r <= 1'b0;                                       // [RULE_06]
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      watchdog_control_r <= WDT_CTRL_RESET;                            // [RULE_05]
    else if (soft_rst)
      watchdog_control_r <= WDT_CTRL_RESET;                            // [RULE_05]
    else if (wr_en && req_r.addr == ADDR_WDT_CTRL)
      watchdog_control_r <= hwdata[7:0];
  end

  // Warm resets leave these alone so software state survives a pin reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sel_r   <= PIN_SEL_RESET;
      port_data_o <= PORT_RESET;                           // [RULE_12]
      port_dir_o  <= PORT_RESET;                           // [RULE_12]
    end else if (wr_en) begin
      if (req_r.addr == ADDR_PIN_CTRL)
        pin_sel_r <= hwdata[0];
      if (req_r.addr == ADDR_PORT_INIT) begin
        port_data_o <= hwdata[7:0];                        // [RULE_15]
        port_dir_o  <= hwdata[15:8];                       // [RULE_15]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pin_is_io_o <= 1'b1;
    else
      pin_is_io_o <= !(cfg_reset_pin_en && pin_sel_r);     // [RULE_14]
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Zero wait states; read data is latched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r     <= '0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      req_r.valid <= hsel && htrans[1] && hready;
      req_r.write <= hwrite;
      req_r.addr  <= haddr;
      if (rd_take) begin
        unique case (haddr)
          ADDR_WDT_CTRL:  hrdata <= {24'h000000, watchdog_control_r};
          ADDR_RST_CAUSE: hrdata <= {31'h00000000, wrf_r};
          ADDR_STATUS:    hrdata <= {cnt_r, 10'h000, state_r, power_down_flag_o,
                                     timeout_flag_o};
          ADDR_PIN_CTRL:  hrdata <= {31'h00000000, pin_sel_r};
          ADDR_PORT_INIT: hrdata <= {16'h0000, port_dir_o, port_data_o};
          default:        hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sw_fire;
    !pin_act && fire_sw;
  endsequence

  sequence s_ovf_run;
    ovf && !low_power_i && !pin_act && !key_bad;
  endsequence

  a_key_reset_flag: assert property (s_sw_fire |=> wrf_r && dev_reset_o) // [RULE_04]
    else $error("key reset did not set flag and reset");
  a_key_flag_sticky: assert property ( // [RULE_06]
    wrf_r && !(wr_en && req_r.addr == ADDR_RST_CAUSE) |=> wrf_r)
    else $error("key reset flag lost without a write");
  a_ovf_normal: assert property (s_ovf_run |=> dev_reset_o && timeout_flag_o) // [RULE_07]
    else $error("normal overflow did not reset");
  a_ovf_sleep: assert property (ovf && low_power_i && !pin_act // [RULE_08]
    |=> pc_sp_reset_o && timeout_flag_o && !dev_reset_o)
    else $error("sleep overflow handled wrongly");
  a_halt_flags: assert property (halt_i && !ovf // [RULE_17]
    |=> power_down_flag_o && !timeout_flag_o)
    else $error("halt flags wrong");
  a_clr_count: assert property (clear_watchdog_instruction_i || halt_i |=> cnt_r == '0) // [RULE_09]
    else $error("counter not cleared");
  a_disabled_stop: assert property (key == KEY_DISABLE && !dev_reset_o // [RULE_03] [RULE_16]
    ##1 key == KEY_DISABLE |-> $stable(cnt_r) || cnt_r == '0)
    else $error("disabled watchdog counted");
  a_pin_hold: assert property (pin_act |=> dev_reset_o [*2]) // [RULE_13]
    else $error("pin reset not held");
  a_startup_len: assert property ($fell(pin_act) && state_r == ST_PIN_LOW // [RULE_13]
    |=> dev_reset_o [*3])
    else $error("start-up delay too short");

endmodule

`default_nettype wire

// ---- shared/wrc_pkg.sv ----
// Constants, types and helpers for the watchdog and reset control block.
// Assumes a single 10 MHz system clock and word-wide AHB-Lite register access.
`default_nettype none

package wrc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 10_000_000;
  localparam int unsigned LS_CLK_HZ       = 32_000;
  // Longest whole period of the low-speed tick, rounded down
  localparam int unsigned LS_DIV_CYC      = SYS_CLK_HZ / LS_CLK_HZ;
  localparam int unsigned SW_RESET_DELAY_US         = 100;
  localparam int unsigned SW_RESET_DELAY_CYC        = SW_RESET_DELAY_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned PIN_RESET_EXTRA_DELAY_US  = 100;
  localparam int unsigned PIN_RESET_EXTRA_DELAY_CYC =
    PIN_RESET_EXTRA_DELAY_US * (SYS_CLK_HZ / 1_000_000);

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0]  ADDR_WDT_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_RST_CAUSE  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h08;
  localparam logic [7:0]  ADDR_PIN_CTRL   = 8'h0C;
  localparam logic [7:0]  ADDR_PORT_INIT  = 8'h10;
  localparam logic [7:0]  WDT_CTRL_RESET  = 8'h53;
  localparam logic [4:0]  KEY_ENABLE      = 5'h0A;
  localparam logic [4:0]  KEY_DISABLE     = 5'h15;
  localparam int unsigned KEY_LSB         = 3;
  localparam int unsigned WRF_BIT         = 0;
  localparam logic        PIN_SEL_RESET   = 1'b0;
  localparam logic [7:0]  PORT_RESET      = 8'hFF;
  localparam int unsigned CNT_W           = 18;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SW_WAIT, ST_PIN_LOW, ST_STARTUP} wrc_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } wrc_ahb_req_t;

  // Mask of low counter bits that are all ones on the last tick of a period
  function automatic logic [CNT_W-1:0] wrc_period_mask(input logic [2:0] code);
    logic [CNT_W-1:0] m;
    m = '0;
    unique case (code)
      3'h0: m = 18'h000FF;
      3'h1: m = 18'h003FF;
      3'h2: m = 18'h00FFF;
      3'h3: m = 18'h03FFF;
      3'h4: m = 18'h07FFF;
      3'h5: m = 18'h0FFFF;
      3'h6: m = 18'h1FFFF;
      3'h7: m = 18'h3FFFF;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// ---- dv/wrc_watchdog_reset_control_tb.sv ----
// Self-checking bench for the watchdog and reset control block.
// Assumes a single AHB-Lite master (this bench) and a 10 MHz hclk.
`default_nettype none

module wrc_watchdog_reset_control_tb
  import wrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Short delays keep the run small
  localparam int SW = 8;
  localparam int PX = 6;

  logic        hclk              = 1'b0;
  logic        hresetn           = 1'b0;
  logic        hsel              = 1'b0;
  logic [7:0]  haddr             = 8'h00;
  logic [1:0]  htrans            = 2'h0;
  logic        hwrite            = 1'b0;
  logic [31:0] hwdata            = 32'h0;
  logic        clear_watchdog_instruction_i         = 1'b0;
  logic        halt_i            = 1'b0;
  logic        low_power_i       = 1'b0;
  logic        ext_reset_pin_n   = 1'b1;
  logic        cfg_reset_pin_en  = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        dev_reset_o;
  logic        pc_sp_reset_o;
  logic        timeout_flag_o;
  logic        power_down_flag_o;
  logic        pin_is_io_o;
  logic [7:0]  port_data_o;
  logic [7:0]  port_dir_o;
  int          bad_count         = 0;
  int          n_compared        = 0;
  int          cnt;
  logic [4:0]  k;
  logic [2:0]  c;
  logic [15:0] pv;

  always #50 hclk = ~hclk;

  wrc_watchdog_reset_control #(.SW_RESET_DLY_CYC(SW), .PIN_EXTRA_DLY_CYC(PX)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .clear_watchdog_instruction_i(clear_watchdog_instruction_i),
    .halt_i(halt_i), .low_power_i(low_power_i), .ext_reset_pin_n(ext_reset_pin_n),
    .cfg_reset_pin_en(cfg_reset_pin_en), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dev_reset_o(dev_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
    .timeout_flag_o(timeout_flag_o), .power_down_flag_o(power_down_flag_o),
    .pin_is_io_o(pin_is_io_o), .port_data_o(port_data_o), .port_dir_o(port_dir_o)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] ctrl_val(input logic [4:0] key, input logic [2:0] code);
    return {24'h0, key, code};
  endfunction

  // Timeout in low-speed ticks for a period code
  function automatic int ticks(input logic [2:0] code);
    return (code < 3'h3) ? (1 << (8 + 2 * code)) : (1 << (11 + code));
  endfunction

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
    chk({hreadyout, hresp}, 32'h2, "bus okay");
  endtask

  // One-cycle instruction strobe: halt when halt_sel, else clear-watchdog
  task automatic pulse(input bit halt_sel);
    if (halt_sel) begin
      halt_i <= 1'b1;
    end else begin
      clear_watchdog_instruction_i <= 1'b1;
    end
    @(posedge hclk);
    halt_i    <= 1'b0;
    clear_watchdog_instruction_i <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // Counts edges until the chosen reset output shows level v, bounded
  task automatic wait_lvl(input bit pcsp, input logic v, input int lim, output int n);
    n = 0;
    while ((pcsp ? pc_sp_reset_o : dev_reset_o) !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic in_range(input int n, input int lo, input int hi, input string what);
    chk(32'(n >= lo && n <= hi), 32'h1, what);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (95000) @(posedge hclk);
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(32'h88c2));
    repeat (4) @(posedge hclk);
    chk(dev_reset_o, 32'h1, "reset held");
    chk({port_dir_o, port_data_o}, 32'hFFFF, "ports");
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_WDT_CTRL, 32'h53, "ctrl por");
    rd(ADDR_PORT_INIT, 32'hFFFF, "port por");
    rd(ADDR_RST_CAUSE, 32'h0, "cause por");
    chk(pin_is_io_o, 32'h1, "pin io por");
    rd(8'h1C, 32'h0, "unmapped");
    // Every period code, each under one randomly chosen valid key
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      k = ($urandom % 2) ? KEY_ENABLE : KEY_DISABLE;
      wr(ADDR_WDT_CTRL, ctrl_val(k, c));
      rd(ADDR_WDT_CTRL, ctrl_val(k, c), "ctrl rw");
      chk(dev_reset_o, 32'h0, "no reset valid key");
    end
    // Bad key: delayed reset, flag, control reload
    do k = 5'($urandom); while (k == KEY_ENABLE || k == KEY_DISABLE);
    wr(ADDR_WDT_CTRL, ctrl_val(k, 3'($urandom)));
    wait_lvl(1'b0, 1'b1, 100, cnt);
    in_range(cnt, SW - 1, SW + 3, "sw delay");
    wait_lvl(1'b0, 1'b0, 100, cnt);
    in_range(cnt, PX, PX + 2, "sw reset len");
    rd(ADDR_RST_CAUSE, 32'h1, "key flag set");
    rd(ADDR_WDT_CTRL, 32'h53, "ctrl reload");
    wr(ADDR_RST_CAUSE, 32'h1);
    rd(ADDR_RST_CAUSE, 32'h1, "flag one write");
    wr(ADDR_RST_CAUSE, 32'h0);
    rd(ADDR_RST_CAUSE, 32'h0, "flag cleared");
    // Pin reset: only with option and select, warm
    pv = 16'($urandom);
    wr(ADDR_PORT_INIT, {16'h0, pv});
    wr(ADDR_PIN_CTRL, 32'h1);
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(dev_reset_o, 32'h0, "pin ignored");
    ext_reset_pin_n <= 1'b1;
    cfg_reset_pin_en <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(pin_is_io_o, 32'h0, "pin is reset");
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(dev_reset_o, 32'h1, "pin held");
    ext_reset_pin_n <= 1'b1;
    wait_lvl(1'b0, 1'b0, 100, cnt);
    in_range(cnt, PX, PX + 2, "pin extra");
    rd(ADDR_PORT_INIT, {16'h0, pv}, "port kept");
    // Halt and clear instruction flags
    pulse(1'b1);
    chk({timeout_flag_o, power_down_flag_o}, 32'h1, "halt flags");
    pulse(1'b0);
    chk(power_down_flag_o, 32'h0, "clear pd");
    // Overflow while in low power: only PC and stack reset
    wr(ADDR_WDT_CTRL, ctrl_val(KEY_ENABLE, 3'h0));
    low_power_i <= 1'b1;
    pulse(1'b0);
    wait_lvl(1'b1, 1'b1, 85000, cnt);
    // Phase of the low-speed tick is unknown, so allow one tick either way
    in_range(cnt, (ticks(3'h0) - 1) * LS_DIV_CYC, (ticks(3'h0) + 1) * LS_DIV_CYC,
             "period");
    @(posedge hclk);
    chk({pc_sp_reset_o, timeout_flag_o, dev_reset_o}, 32'h2, "sleep overflow");
    low_power_i <= 1'b0;
    rd(ADDR_WDT_CTRL, ctrl_val(KEY_ENABLE, 3'h0), "state kept");
    pulse(1'b1);
    chk(timeout_flag_o, 32'h0, "halt clears to");
    results();
  end

endmodule

`default_nettype wire
